// ---- design/omw_cfg.svh ----
`ifndef OMW_CFG_SVH
`define OMW_CFG_SVH
// register offsets on the plain port
`define OMW_ADDR_MODE 4'h0
`define OMW_ADDR_MODE2 4'h1
`define OMW_ADDR_STATUS 4'h2
`define OMW_ADDR_WAKE_EN 4'h3
`define OMW_ADDR_IRQ_EN 4'h4
`define OMW_ADDR_CMD 4'h5
`define OMW_ADDR_CLKSTAT 4'h6
// mode and mode2 register fields
`define OMW_BIT_HLSEL 0
`define OMW_BIT_IDLE 1
`define OMW_LSB_DIV 5
`define OMW_MSB_DIV 7
`define OMW_BIT_KEEP 7
// status register fields
`define OMW_BIT_PDF 0
`define OMW_BIT_TOF 1
`define OMW_BIT_LRDY 2
`define OMW_BIT_HRDY 3
// command register bits
`define OMW_CMD_HALT 0
`define OMW_CMD_CLRWDT 1
// reset values
`define OMW_MODE_RST 8'h03
`define OMW_MODE2_RST 8'h00
// divider codes at or below this select the sub clock while the low select is chosen
`define OMW_DIV_SUB_MAX 3'h1
`define OMW_DIV_H64 3'h2
`define OMW_DIV_H32 3'h3
`define OMW_DIV_H16 3'h4
`define OMW_DIV_H8 3'h5
`define OMW_DIV_H4 3'h6
`define OMW_DIV_H2 3'h7
// high-speed settle count after restart
`define OMW_HSETTLE_CYC 11'h400
`define OMW_HSETTLE_ZERO 11'h000
`define OMW_HSETTLE_ONE 11'h001
`define OMW_NPIN 8
`endif

// ---- design/omw_pkg.sv ----
`default_nettype none
package omw_pkg;
  // operating and low-power states
  typedef enum logic [2:0] {
    OMW_NORMAL = 3'b000,
    OMW_SLOW = 3'b001,
    OMW_DEEP_SLEEP_STATE = 3'b010,
    OMW_SLEEP_WITH_SUB_CLOCK = 3'b011,
    OMW_IDLE_SYSCLK_OFF = 3'b100,
    OMW_IDLE_SYSCLK_ON = 3'b101
  } omw_state_t;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } omw_bus_t;
  // clock enables towards the clock tree
  typedef struct packed {
    logic hosc_on;
    logic sub_on;
    logic sys_from_sub;
    logic sys_run;
    logic div16_on;
    logic div64_on;
    logic [2:0] div_sel;
  } omw_clk_t;
  // wake outcomes towards the core
  typedef struct packed {
    logic full_reset;
    logic wdt_reset;
    logic resume_next;
    logic irq_vector;
    logic irq_pend;
  } omw_wake_t;
endpackage
`default_nettype wire

// ---- design/omw_edge_det.sv ----
`include "omw_cfg.svh"
`default_nettype none
// per-pin falling edge detect, gated by each pin's own enable
module omw_edge_det
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [`OMW_NPIN-1:0] pins,
  input wire logic [`OMW_NPIN-1:0] en,
  output logic any_fall
);
  // previous pin levels; reset high so no false edge at start
  logic [`OMW_NPIN-1:0] prev_ff;
  logic [`OMW_NPIN-1:0] fall;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      prev_ff <= {`OMW_NPIN{1'b1}};
    else
      prev_ff <= pins;
  end
  genvar g;
  generate
    for (g = 0; g < `OMW_NPIN; g = g + 1)
    begin : g_pin
      // negative transition on an enabled pin
      assign fall[g] = en[g] & prev_ff[g] & ~pins[g];
    end
  endgenerate
  assign any_fall = |fall;
endmodule
`default_nettype wire

// ---- design/omw_ctrl.sv ----
// Operation
// - sub clock when low select, divider 000/001
// - high clock when select set or divider 010+
// - sub clock use stops high source, /16, /64
// - slow entry waits for low-osc ready flag (a wake from sleep enters slow without waiting)
// - high-osc ready flag shown on return
// - halt, idle 0, watchdog/detector off: deep sleep
// - idle 1, keep 0: sysclk off, sub on
// - idle 1, keep 1: both clocks run
// - halt freezes execution, memory, ports
// - low-power entry sets pdf, clears timeout
// - wake on reset, port edge, irq, watchdog
// - reset wake full reset; watchdog wake reset
// - pdf cleared by power-up/clear, set by halt
// - watchdog wake sets timeout, pc/sp reset only
// - per-pin falling-edge wake enable, resume next
// - disabled irq or full stack: resume, pending
// - enabled irq, stack free: normal response
// - irq already pending before halt cannot wake
//
// Local design decisions: the placing of the registers and the strobed register port.
`include "omw_cfg.svh"
`default_nettype none
module omw_ctrl
  import omw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire omw_pkg::omw_bus_t bus,
  output logic [7:0] rdata,
  input wire logic ext_reset_req,
  input wire logic [`OMW_NPIN-1:0] port_a,
  input wire logic [7:0] irq_req,
  input wire logic stack_full,
  input wire logic wdt_enabled,
  input wire logic lvd_enabled,
  input wire logic wdt_overflow,
  input wire logic low_osc_stable,
  output omw_pkg::omw_clk_t clk_ctl,
  output omw_pkg::omw_wake_t wake,
  output logic cpu_hold,
  output logic wdt_clear,
  output logic wdt_hold,
  output omw_pkg::omw_state_t state_out
);
  import omw_pkg::*;

  // software-visible control
  logic [7:0] mode_ff; // mode_control_register
  logic [7:0] mode2_ff; // mode_control_register_two
  logic [`OMW_NPIN-1:0] wake_en_ff; // port_a_wake_enable
  logic [7:0] irq_en_ff; // per-source interrupt enable
  logic power_down_flag_ff;
  logic watchdog_timeout_flag_ff;
  logic high_osc_ready_flag_ff;
  logic [10:0] hsettle_ff; // high-speed restart settle counter
  logic [7:0] irq_mask_ff; // requests pending at halt, barred from waking
  omw_state_t state_ff;
  omw_state_t nxt_state;
  logic [7:0] rdata_ff;
  omw_clk_t clk_ff;
  omw_clk_t nxt_clk;
  omw_wake_t wake_ff;
  omw_wake_t nxt_wake;
  logic cpu_hold_ff;
  logic wdt_clear_ff;
  logic wdt_hold_ff;

  // decoded controls
  logic hl_sel;
  logic idle_on_halt;
  logic keep_sysclk_in_idle;
  logic [2:0] clock_divider_select;
  logic want_sub;
  logic halt_cmd;
  logic clr_cmd;
  logic asleep;
  logic port_wake;
  logic [7:0] irq_wake;
  logic any_irq_wake;
  logic irq_serviceable;

  assign hl_sel = mode_ff[`OMW_BIT_HLSEL];
  assign idle_on_halt = mode_ff[`OMW_BIT_IDLE];
  assign clock_divider_select = mode_ff[`OMW_MSB_DIV:`OMW_LSB_DIV];
  assign keep_sysclk_in_idle = mode2_ff[`OMW_BIT_KEEP];
  // sub clock only for low select with divider 000 or 001
  assign want_sub = !hl_sel && (clock_divider_select <= `OMW_DIV_SUB_MAX);
  assign halt_cmd = bus.wr && (bus.addr == `OMW_ADDR_CMD) && bus.wdata[`OMW_CMD_HALT];
  assign clr_cmd = bus.wr && (bus.addr == `OMW_ADDR_CMD) && bus.wdata[`OMW_CMD_CLRWDT];
  assign asleep = (state_ff != OMW_NORMAL) && (state_ff != OMW_SLOW);
  // only requests that were not already raised at halt may wake
  assign irq_wake = irq_req & ~irq_mask_ff;
  assign any_irq_wake = |irq_wake;
  assign irq_serviceable = |(irq_wake & irq_en_ff) && !stack_full;

  // port a edge detection lives in its own leaf
  omw_edge_det u_edge
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pins(port_a),
    .en(wake_en_ff),
    .any_fall(port_wake)
  );

  // software registers; halt and clear are pulses, not stored
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mode_ff <= `OMW_MODE_RST;
      mode2_ff <= `OMW_MODE2_RST;
      wake_en_ff <= '0;
      irq_en_ff <= '0;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        `OMW_ADDR_MODE: mode_ff <= bus.wdata;
        `OMW_ADDR_MODE2: mode2_ff <= bus.wdata;
        `OMW_ADDR_WAKE_EN: wake_en_ff <= bus.wdata;
        `OMW_ADDR_IRQ_EN: irq_en_ff <= bus.wdata;
        default: ;
      endcase
    end
  end

  // mode sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      OMW_NORMAL, OMW_SLOW:
      begin
        if (halt_cmd)
        begin
          // low-power choice made at the halt itself
          if (idle_on_halt && keep_sysclk_in_idle)
            nxt_state = OMW_IDLE_SYSCLK_ON;
          else if (idle_on_halt)
            nxt_state = OMW_IDLE_SYSCLK_OFF;
          else if (wdt_enabled || lvd_enabled)
            nxt_state = OMW_SLEEP_WITH_SUB_CLOCK;
          else
            nxt_state = OMW_DEEP_SLEEP_STATE;
        end
        else if (want_sub && low_osc_stable)
          nxt_state = OMW_SLOW;
        else if (!want_sub)
          nxt_state = OMW_NORMAL;
      end
      OMW_DEEP_SLEEP_STATE, OMW_SLEEP_WITH_SUB_CLOCK,
      OMW_IDLE_SYSCLK_OFF, OMW_IDLE_SYSCLK_ON:
      begin
        // any wake source other than external reset returns to the selected run mode
        if (ext_reset_req || port_wake || any_irq_wake || wdt_overflow)
          nxt_state = want_sub ? OMW_SLOW : OMW_NORMAL;
      end
      default: nxt_state = OMW_NORMAL;
    endcase
    // external reset always wins and lands in the reset mode
    if (ext_reset_req)
      nxt_state = OMW_NORMAL;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      state_ff <= OMW_NORMAL;
    else
      state_ff <= nxt_state;
  end

  // requests already raised at halt are masked until they drop
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      irq_mask_ff <= '0;
    else if (halt_cmd && !asleep)
      irq_mask_ff <= irq_req;
    else
      irq_mask_ff <= irq_mask_ff & irq_req;
  end

  // power-down and timeout flags; external reset clear wins over any set, halt over clear and overflow
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      power_down_flag_ff <= 1'b0;
      watchdog_timeout_flag_ff <= 1'b0;
    end
    else if (ext_reset_req)
    begin
      // full reset brings flags back to power-up values
      power_down_flag_ff <= 1'b0;
      watchdog_timeout_flag_ff <= 1'b0;
    end
    else if (halt_cmd && !asleep)
    begin
      power_down_flag_ff <= 1'b1;
      watchdog_timeout_flag_ff <= 1'b0;
    end
    else
    begin
      if (clr_cmd)
        power_down_flag_ff <= 1'b0;
      if (wdt_overflow)
        watchdog_timeout_flag_ff <= 1'b1;
    end
  end

  // high-speed ready: drops while the source is off, rises after settling
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hsettle_ff <= `OMW_HSETTLE_ZERO;
      high_osc_ready_flag_ff <= 1'b1;
    end
    else if (!nxt_clk.hosc_on)
    begin
      hsettle_ff <= `OMW_HSETTLE_CYC;
      high_osc_ready_flag_ff <= 1'b0;
    end
    else if (hsettle_ff > `OMW_HSETTLE_ONE)
      hsettle_ff <= hsettle_ff - `OMW_HSETTLE_ONE;
    else
    begin
      hsettle_ff <= `OMW_HSETTLE_ZERO;
      high_osc_ready_flag_ff <= 1'b1;
    end
  end

  // clock tree enables follow the state; div_sel follows the divider bits in every state except deep sleep, where it is zero
  always_comb
  begin
    nxt_clk = '0;
    nxt_clk.div_sel = clock_divider_select;
    case (nxt_state)
      OMW_NORMAL:
      begin
        nxt_clk.hosc_on = 1'b1;
        nxt_clk.sub_on = 1'b1;
        nxt_clk.sys_run = 1'b1;
      end
      OMW_SLOW:
      begin
        // high source and its /16, /64 taps stay off here
        nxt_clk.sub_on = 1'b1;
        nxt_clk.sys_from_sub = 1'b1;
        nxt_clk.sys_run = 1'b1;
      end
      OMW_IDLE_SYSCLK_ON:
      begin
        // keep the run clock that was live at the halt; re-deciding from the
        // select bits could leave the core on a sub clock not yet stable
        if (state_ff == OMW_IDLE_SYSCLK_ON)
          nxt_clk.sys_from_sub = clk_ff.sys_from_sub;
        else
          nxt_clk.sys_from_sub = (state_ff == OMW_SLOW);
        nxt_clk.hosc_on = !nxt_clk.sys_from_sub;
        nxt_clk.sub_on = 1'b1;
        nxt_clk.sys_run = 1'b1;
      end
      OMW_IDLE_SYSCLK_OFF, OMW_SLEEP_WITH_SUB_CLOCK:
        nxt_clk.sub_on = 1'b1;
      OMW_DEEP_SLEEP_STATE: nxt_clk = '0;
      default: nxt_clk = '0;
    endcase
    // derived taps only exist while the high source runs
    nxt_clk.div16_on = nxt_clk.hosc_on;
    nxt_clk.div64_on = nxt_clk.hosc_on;
  end

  // registered enables so the clock gates see clean, single-edge changes
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      clk_ff <= '0;
    else
      clk_ff <= nxt_clk;
  end

  // wake outcome pulses towards the core
  always_comb
  begin
    nxt_wake = '0;
    if (asleep && ext_reset_req)
      nxt_wake.full_reset = 1'b1;
    else if (asleep && wdt_overflow)
      nxt_wake.wdt_reset = 1'b1;
    else if (asleep && any_irq_wake && irq_serviceable)
      nxt_wake.irq_vector = 1'b1;
    else if (asleep && any_irq_wake)
    begin
      nxt_wake.resume_next = 1'b1;
      nxt_wake.irq_pend = 1'b1;
    end
    else if (asleep && port_wake)
      nxt_wake.resume_next = 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      wake_ff <= '0;
    else
      wake_ff <= nxt_wake;
  end

  // core hold and watchdog handling
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cpu_hold_ff <= 1'b0;
      wdt_clear_ff <= 1'b0;
      wdt_hold_ff <= 1'b0;
    end
    else
    begin
      cpu_hold_ff <= (nxt_state != OMW_NORMAL) && (nxt_state != OMW_SLOW);
      wdt_clear_ff <= (halt_cmd && !asleep) || clr_cmd;
      wdt_hold_ff <= (nxt_state == OMW_DEEP_SLEEP_STATE);
    end
  end

  // read port: data in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_ff <= '0;
    else if (bus.rd)
    begin
      case (bus.addr)
        `OMW_ADDR_MODE: rdata_ff <= mode_ff;
        `OMW_ADDR_MODE2: rdata_ff <= mode2_ff;
        `OMW_ADDR_WAKE_EN: rdata_ff <= wake_en_ff;
        `OMW_ADDR_IRQ_EN: rdata_ff <= irq_en_ff;
        `OMW_ADDR_STATUS:
        begin
          rdata_ff <= '0;
          rdata_ff[`OMW_BIT_PDF] <= power_down_flag_ff;
          rdata_ff[`OMW_BIT_TOF] <= watchdog_timeout_flag_ff;
          rdata_ff[`OMW_BIT_LRDY] <= low_osc_stable;
          rdata_ff[`OMW_BIT_HRDY] <= high_osc_ready_flag_ff;
        end
        `OMW_ADDR_CLKSTAT: rdata_ff <= {clk_ff[6:2], state_ff};
        default: rdata_ff <= '0; // unmapped reads zero
      endcase
    end
    else
      rdata_ff <= '0;
  end

  assign rdata = rdata_ff;
  assign clk_ctl = clk_ff;
  assign wake = wake_ff;
  assign cpu_hold = cpu_hold_ff;
  assign wdt_clear = wdt_clear_ff;
  assign wdt_hold = wdt_hold_ff;
  assign state_out = state_ff;
endmodule
`default_nettype wire

// ---- verification/omw_ctrl_chk.sv ----
`include "omw_cfg.svh"
`default_nettype none
// watches the controller ports only; all checks share one clock
module omw_ctrl_chk
  import omw_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire omw_pkg::omw_bus_t bus,
  input wire logic ext_reset_req,
  input wire logic wdt_overflow,
  input wire omw_pkg::omw_clk_t clk_ctl,
  input wire omw_pkg::omw_wake_t wake,
  input wire logic cpu_hold,
  input wire logic wdt_clear,
  input wire logic wdt_hold,
  input wire omw_pkg::omw_state_t state_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // every low-power state code has bit 2 or bit 1 set
  logic asleep;
  assign asleep = state_out[2] | state_out[1];
  // halt taken while running, with no competing wake cause
  sequence halt_s;
    bus.wr && bus.addr == `OMW_ADDR_CMD && bus.wdata[`OMW_CMD_HALT] && !asleep
      && !ext_reset_req && !wdt_overflow;
  endsequence
  // a wake cause seen while in a low-power state
  sequence wake_s(src);
    asleep && src;
  endsequence
  halt_entry_a: assert property (halt_s |=> cpu_hold && wdt_clear)
    else $error("halt did not freeze core or clear watchdog");
  hold_level_a: assert property (asleep |-> cpu_hold)
    else $error("core runs in low-power state");
  deep_stop_a: assert property (state_out == OMW_DEEP_SLEEP_STATE |->
    !clk_ctl.sub_on && !clk_ctl.sys_run && wdt_hold)
    else $error("deep sleep left a clock or watchdog running");
  sub_keep_a: assert property (state_out inside {OMW_SLEEP_WITH_SUB_CLOCK,
    OMW_IDLE_SYSCLK_OFF} |-> clk_ctl.sub_on && !clk_ctl.sys_run && !wdt_hold)
    else $error("sub clock state has wrong clocks");
  idle_run_a: assert property (state_out == OMW_IDLE_SYSCLK_ON |->
    clk_ctl.sub_on && clk_ctl.sys_run)
    else $error("idle with clock kept stopped a clock");
  sub_stop_a: assert property (clk_ctl.sys_from_sub |->
    !clk_ctl.hosc_on && !clk_ctl.div16_on && !clk_ctl.div64_on)
    else $error("high source runs while on sub clock");
  ext_wake_a: assert property (wake_s(ext_reset_req) |=> wake.full_reset)
    else $error("external reset wake missed full reset");
  wdt_wake_a: assert property (wake_s(wdt_overflow && !ext_reset_req) |=>
    wake.wdt_reset && !wake.full_reset)
    else $error("watchdog wake gave wrong reset");
  port_wake_a: assert property (wake.resume_next |-> !cpu_hold ##1 !wake.resume_next)
    else $error("resume pulse without release or too long");
endmodule
bind omw_ctrl omw_ctrl_chk u_chk (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .bus(bus),
  .ext_reset_req(ext_reset_req),
  .wdt_overflow(wdt_overflow),
  .clk_ctl(clk_ctl),
  .wake(wake),
  .cpu_hold(cpu_hold),
  .wdt_clear(wdt_clear),
  .wdt_hold(wdt_hold),
  .state_out(state_out)
);
`default_nettype wire

// ---- verification/omw_ctrl_tb.sv ----
`include "omw_cfg.svh"
`default_nettype none
module omw_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import omw_pkg::*;
  // one halt case: mode, keep bit, wdt, lvd, state, wake cause, pulse, flags
  typedef struct packed {
    logic [7:0] mode;
    logic keep, wdt, low_voltage_detector;
    omw_state_t st;
    logic [2:0] src;
    logic [4:0] w;
    logic [1:0] stat;
  } omw_row_t;
  // causes: 0 port edge, 1 irq on, 2 irq off, 3 stack full, 4 watchdog
  omw_row_t rows[5] = '{
    '{8'h01, 1'b0, 1'b0, 1'b0, OMW_DEEP_SLEEP_STATE, 3'd0, 5'h04, 2'h1},
    '{8'h01, 1'b0, 1'b1, 1'b0, OMW_SLEEP_WITH_SUB_CLOCK, 3'd1, 5'h02, 2'h1},
    '{8'h01, 1'b0, 1'b0, 1'b1, OMW_SLEEP_WITH_SUB_CLOCK, 3'd2, 5'h05, 2'h1},
    '{8'h03, 1'b0, 1'b0, 1'b0, OMW_IDLE_SYSCLK_OFF, 3'd3, 5'h05, 2'h1},
    '{8'h03, 1'b1, 1'b1, 1'b0, OMW_IDLE_SYSCLK_ON, 3'd4, 5'h08, 2'h3}};
  // mode values walked through the clock select
  logic [7:0] mv[10] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'he0, 8'h00, 8'h01};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  omw_bus_t bus = '0;
  logic ext_reset_req = 1'b0, stack_full = 1'b0, wdt_enabled = 1'b0, lvd_enabled = 1'b0;
  logic wdt_overflow = 1'b0, low_osc_stable = 1'b1, cpu_hold, wdt_clear, wdt_hold;
  logic [7:0] port_a = 8'hff, irq_req = 8'h00, rdata, d;
  logic slow; // expected sub clock outcome of one mode value
  omw_clk_t clk_ctl;
  omw_wake_t wake, w;
  omw_state_t state_out;
  int num_errors = 0, samples_checked = 0;
  omw_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .ext_reset_req(ext_reset_req), .port_a(port_a), .irq_req(irq_req),
    .stack_full(stack_full), .wdt_enabled(wdt_enabled), .lvd_enabled(lvd_enabled),
    .wdt_overflow(wdt_overflow), .low_osc_stable(low_osc_stable), .clk_ctl(clk_ctl),
    .wake(wake), .cpu_hold(cpu_hold), .wdt_clear(wdt_clear), .wdt_hold(wdt_hold),
    .state_out(state_out));
  // 40 MHz
  initial forever #12.5 ref_clk = ~ref_clk;
  task conclude;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle strobes, launched just after an edge
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge ref_clk) bus <= {2'b10, a, v};
    @(posedge ref_clk) bus <= '0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge ref_clk) bus <= {2'b01, a, 8'h00};
    @(posedge ref_clk) bus <= '0;
    #1 d = rdata;
  endtask
  // read one register and compare its masked value
  task rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(d & m, e);
  endtask
  // bounded waits; running out is a failure
  task wait_wake;
    int n;
    for (n = 0; n < 16 && wake === '0; n++)
      @(posedge ref_clk) #1;
    w = wake;
    if (n == 16)
    begin
      num_errors++;
      conclude();
    end
  endtask
  task wait_state(input omw_state_t s);
    int n;
    // let a just-written mode reach the state and the clock enables first
    @(posedge ref_clk) #1;
    for (n = 0; n < 1200 && state_out !== s; n++)
      @(posedge ref_clk) #1;
    chk({5'h00, state_out}, {5'h00, s});
  endtask
  task halt;
    wr(`OMW_ADDR_CMD, 8'h01);
    @(posedge ref_clk) #1;
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    // register defaults, write-only and unmapped places read zero
    rc(`OMW_ADDR_MODE, 8'hff, `OMW_MODE_RST);
    rc(`OMW_ADDR_MODE2, 8'hff, `OMW_MODE2_RST);
    rc(`OMW_ADDR_CMD, 8'hff, 8'h00);
    rc(4'h7, 8'hff, 8'h00);
    rc(`OMW_ADDR_STATUS, 8'h0b, 8'h08);
    // reset mode runs the high source with both taps, system clock on
    rc(`OMW_ADDR_CLKSTAT, 8'hff, {5'b01110, OMW_NORMAL});
    $display("reset test done");
    wr(`OMW_ADDR_WAKE_EN, 8'h01);
    foreach (rows[i])
    begin
      wr(`OMW_ADDR_MODE, rows[i].mode);
      wr(`OMW_ADDR_MODE2, {rows[i].keep, 7'h00});
      wr(`OMW_ADDR_IRQ_EN, {7'h00, rows[i].src inside {3'd1, 3'd3}});
      @(posedge ref_clk) wdt_enabled <= rows[i].wdt;
      lvd_enabled <= rows[i].low_voltage_detector;
      stack_full <= rows[i].src == 3'd3;
      halt();
      chk({5'h00, state_out}, {5'h00, rows[i].st});
      rc(`OMW_ADDR_STATUS, 8'h03, 8'h01);
      @(posedge ref_clk)
      case (rows[i].src)
        3'd0: port_a <= 8'hfe;
        3'd4: wdt_overflow <= 1'b1;
        default: irq_req <= 8'h01;
      endcase
      wait_wake();
      chk({3'h0, w}, {3'h0, rows[i].w});
      @(posedge ref_clk) port_a <= 8'hff;
      irq_req <= 8'h00;
      wdt_overflow <= 1'b0;
      stack_full <= 1'b0;
      rc(`OMW_ADDR_STATUS, 8'h03, {6'h00, rows[i].stat});
      wr(`OMW_ADDR_CMD, 8'h02);
      rc(`OMW_ADDR_STATUS, 8'h01, 8'h00);
      $display("halt row %0d done", i);
    end
    // an irq already raised before the halt must not wake
    wr(`OMW_ADDR_IRQ_EN, 8'h01);
    @(posedge ref_clk) irq_req <= 8'h01;
    halt();
    repeat (8) @(posedge ref_clk) #1;
    chk({7'h00, cpu_hold}, 8'h01);
    @(posedge ref_clk) port_a <= 8'hfe;
    wait_wake();
    chk({7'h00, w.resume_next}, 8'h01);
    @(posedge ref_clk) port_a <= 8'hff;
    irq_req <= 8'h00;
    $display("pending irq test done");
    // external reset out of a sleep
    halt();
    @(posedge ref_clk) ext_reset_req <= 1'b1;
    wait_wake();
    chk({3'h0, w}, 8'h10);
    @(posedge ref_clk) ext_reset_req <= 1'b0;
    rc(`OMW_ADDR_STATUS, 8'h03, 8'h00);
    $display("external reset test done");
    // slow entry waits for the sub clock to be stable
    @(posedge ref_clk) low_osc_stable <= 1'b0;
    wr(`OMW_ADDR_MODE, 8'h00);
    repeat (4) @(posedge ref_clk) #1;
    chk({5'h00, state_out}, {5'h00, OMW_NORMAL});
    rc(`OMW_ADDR_STATUS, 8'h04, 8'h00);
    @(posedge ref_clk) low_osc_stable <= 1'b1;
    foreach (mv[j])
    begin
      wr(`OMW_ADDR_MODE, mv[j]);
      slow = !mv[j][0] && (mv[j][7:5] <= `OMW_DIV_SUB_MAX);
      wait_state(slow ? OMW_SLOW : OMW_NORMAL);
      chk({7'h00, clk_ctl.sys_from_sub}, {7'h00, slow});
      chk({7'h00, clk_ctl.hosc_on | clk_ctl.div16_on | clk_ctl.div64_on}, {7'h00, !slow});
      chk({5'h00, clk_ctl.div_sel}, {5'h00, mv[j][7:5]});
    end
    // ready flag stays low while the restarted high source settles
    rc(`OMW_ADDR_STATUS, 8'h08, 8'h00);
    repeat (1100) @(posedge ref_clk);
    rc(`OMW_ADDR_STATUS, 8'h08, 8'h08);
    $display("clock switch test done");
    // reset pulled in the middle of a sleep
    halt();
    chk({7'h00, cpu_hold}, 8'h01);
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk) #1;
    chk({4'h0, cpu_hold, state_out}, {4'h0, 1'b0, OMW_NORMAL});
    rc(`OMW_ADDR_MODE, 8'hff, `OMW_MODE_RST);
    rc(`OMW_ADDR_STATUS, 8'h0b, 8'h08);
    $display("mid-run reset test done");
    conclude();
  end
endmodule
`default_nettype wire
